// file: pkg/ump_pkg.sv
// Purpose: shared constants for the modem, line and modem-status block
// Assumes: APB byte addresses, one 32-bit word per register
// Notes:   reserved bits read zero
//
// Functional notes
// - infrared select bit takes the strap pin level after reset release
// - infrared select routes serial lines via IrDA codec; idle IR output low
// - Xon-any: any received char resumes transmission halted by software flow
// - loopback bit selects local loopback; reset value zero
// - send-immediate bit queues holding byte ahead of FIFO if next access writes it; self-clears on next access; in loopback the code does neither
// - send-immediate only with transmitter enabled; flow characters go first
// - in loopback bit 3 drives CD status, bit 2 drives RI status
// - flow-pair select: RTS/CTS at 0, DTR/DSR at 1, only with auto flow
// - control bits 1 and 0 drive active-low RTS and DTR; reset zero
// - line-status interrupt whenever a FIFO character carries an error
// - FIFO error summary set while any parity, framing or break entry remains
// - transmitter empty only when holding FIFO and shift register both empty
// - holding-empty set when last byte leaves FIFO, cleared on load
// - break loads one character; further break characters dropped until line returns to mark
// - framing and parity flags belong to the character at FIFO top
// - character into full FIFO sets overrun and is dropped
// - data ready while the receive FIFO holds a character
// - status bits 7..4 show inverted CD, RI, DSR, CTS or loopback bits
// - with auto flow, high CTS/DSR halts transmit after current char
// - change flags latch on modem input changes and raise modem interrupt
// - ring change flag only on RI input low to high
package ump_pkg;
	localparam int        ADDR_W   = 8;
	localparam logic [7:0] OFF_HOLD = 8'h00;
	localparam logic [7:0] OFF_IER  = 8'h04;
	localparam logic [7:0] OFF_EFR  = 8'h08;
	localparam logic [7:0] OFF_MC   = 8'h0c;
	localparam logic [7:0] OFF_LS   = 8'h10;
	localparam logic [7:0] OFF_MS   = 8'h14;
	localparam logic [7:0] OFF_FC   = 8'h18;

	localparam int MC_DTR  = 0;
	localparam int MC_RTS  = 1;
	localparam int MC_PAIR = 2;
	localparam int MC_IMM  = 3;
	localparam int MC_LOOP = 4;
	localparam int MC_XANY = 5;
	localparam int MC_IR   = 6;
	localparam logic [7:0] MC_RST = 8'h00;

	localparam int IER_LS   = 2;
	localparam int IER_MS   = 3;
	localparam int EFR_AUTO = 6;
	localparam int MS_TXDIS = 3;
	localparam int FC_IRINV = 4;

	localparam int ENT_W   = 11;
	localparam int ENT_PE  = 0;
	localparam int ENT_FE  = 1;
	localparam int ENT_BRK = 2;
	localparam int ENT_DAT = 3;

	localparam int SY_RI    = 0;
	localparam int SY_CD    = 1;
	localparam int SY_DSR   = 2;
	localparam int SY_CTS   = 3;
	localparam int SY_RX    = 4;
	localparam int SY_STRAP = 5;
	localparam int NSYNC    = 6;

	localparam logic [3:0] IR_PULSE_TICKS = 4'h3;
	localparam logic [4:0] IR_HOLD_TICKS  = 5'h10;
	localparam logic [1:0] STRAP_TAKE     = 2'h2;
	localparam logic [1:0] SETTLED        = 2'h3;
endpackage

// file: pkg/rxq_if.sv
`timescale 1ns/10ps
interface rxq_if #(
	parameter int W = 11
);
	logic         push;
	logic [W-1:0] wdata;
	logic         pop;
	logic         full;
	logic         empty;
	logic         err_any;
	logic [W-1:0] top;

	modport ctrl (output push, wdata, pop, input full, empty, err_any, top);
	modport fifo (input push, wdata, pop, output full, empty, err_any, top);
endinterface

// file: src/rx_err_fifo.sv
// Purpose: receive FIFO holding data plus per-character error flags
// Assumes: depth a power of two; push only when not full, pop only when not empty
// Notes:   keeps a running count of flagged entries for the summary bit
`timescale 1ns/10ps
module rx_err_fifo #(
	parameter int W  = 11,
	parameter int D  = 64,
	parameter int AW = $clog2(D)
) (
	input wire logic clk,
	input wire logic rst_n,
	rxq_if.fifo      q
);
	logic [W-1:0]  mem_ff [D];
	logic [AW-1:0] wp_ff;
	logic [AW-1:0] rp_ff;
	logic [AW:0]   cnt_ff;
	logic [AW:0]   ecnt_ff;
	logic          push_err;
	logic          pop_err;

	assign push_err  = |q.wdata[2:0];
	assign pop_err   = |q.top[2:0];
	assign q.top     = mem_ff[rp_ff];
	assign q.full    = (cnt_ff == (AW+1)'(D));
	assign q.empty   = (cnt_ff == '0);
	assign q.err_any = (ecnt_ff != '0);

	always_ff @(posedge clk) begin
		if (q.push)
			mem_ff[wp_ff] <= q.wdata;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wp_ff   <= '0;
			rp_ff   <= '0;
			cnt_ff  <= '0;
			ecnt_ff <= '0;
		end else begin
			if (q.push)
				wp_ff <= wp_ff + 1'b1;
			if (q.pop)
				rp_ff <= rp_ff + 1'b1;
			cnt_ff  <= cnt_ff + (AW+1)'(q.push) - (AW+1)'(q.pop);
			ecnt_ff <= ecnt_ff + (AW+1)'(q.push & push_err) - (AW+1)'(q.pop & pop_err);
		end
	end
endmodule

// file: src/uart_modem_line_status_ctrl.sv
// Purpose: modem control, line status and modem status of one UART channel
// Assumes: transmitter, receiver and baud generator sit outside on pclk
// Notes:   APB slave with one wait state; pin inputs double-synchronised
//
// Decided for this implementation: the placing of the registers and the APB interface to the registers.
`timescale 1ns/10ps
module uart_modem_line_status_ctrl #(
	parameter int FIFO_DEPTH = 64,
	parameter int TXL_W      = 7
) (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic             psel,
	input  wire logic             penable,
	input  wire logic             pwrite,
	input  wire logic [7:0]       paddr,
	input  wire logic [31:0]      pwdata,
	output logic      [31:0]      prdata,
	output logic                  pready,
	output logic                  pslverr,
	input  wire logic             infrared_strap_pin,
	input  wire logic             rx_pin,
	input  wire logic             cts_n_pin,
	input  wire logic             dsr_n_pin,
	input  wire logic             cd_n_pin,
	input  wire logic             ri_n_pin,
	output logic                  tx_pin,
	output logic                  rts_n_pin,
	output logic                  dtr_n_pin,
	input  wire logic             baud_tick16,
	input  wire logic             tx_serial,
	input  wire logic [TXL_W-1:0] tx_fifo_level,
	input  wire logic             tsr_load,
	input  wire logic             tsr_busy,
	input  wire logic             sw_flow_halted,
	input  wire logic             flow_char_pending,
	input  wire logic             imm_take,
	input  wire logic             rx_char_done,
	input  wire logic [7:0]       rx_char,
	input  wire logic             rx_parity_err,
	input  wire logic             rx_framing_err,
	input  wire logic             rx_break,
	output logic                  rx_serial,
	output logic                  thr_push,
	output logic      [7:0]       thr_data,
	output logic                  imm_valid,
	output logic      [7:0]       imm_data,
	output logic                  xon_any_resume,
	output logic                  tx_flow_halt,
	output logic                  tx_disable,
	output logic                  line_status_int,
	output logic                  modem_status_int
);
	logic [ump_pkg::NSYNC-1:0] sync1_ff;
	logic [ump_pkg::NSYNC-1:0] sync2_ff;
	logic [1:0]                strap_cnt_ff;
	logic                      settled;
	logic [7:0]                mc_ff;
	logic [7:0]                ier_ff;
	logic [7:0]                efr_ff;
	logic [7:0]                fc_ff;
	logic                      txdis_ff;
	logic                      pready_ff;
	logic [31:0]               prdata_ff;
	logic                      pslverr_ff;
	logic [31:0]               nxt_prdata;
	logic                      nxt_pslverr;
	logic                      done;
	logic                      wr;
	logic                      rd;
	logic                      loop;
	logic                      ir;
	logic                      imm_pend_ff;
	logic                      nxt_imm_pend;
	logic [7:0]                imm_data_ff;
	logic                      imm_valid_ff;
	logic                      thr_push_ff;
	logic [7:0]                thr_data_ff;
	logic                      thr_empty_ff;
	logic                      tx_empty_ff;
	logic                      ovr_ff;
	logic                      brk_hold_ff;
	logic                      accept;
	logic                      xon_ff;
	logic [7:0]                line_status;
	logic [3:0]                live;
	logic [3:0]                prev_ff;
	logic [3:0]                delta_ff;
	logic [3:0]                nxt_delta;
	logic                      halt_ff;
	logic                      rts_n_ff;
	logic                      dtr_n_ff;
	logic                      ls_int_ff;
	logic                      ms_int_ff;
	logic [3:0]                phase_ff;
	logic                      tx_prev_ff;
	logic [4:0]                dec_cnt_ff;
	logic                      rx_in;
	logic                      tx_pin_ff;
	logic                      rx_serial_ff;

	rxq_if #(.W(ump_pkg::ENT_W)) q ();

	rx_err_fifo #(
		.W (ump_pkg::ENT_W),
		.D (FIFO_DEPTH)
	) u_rxq (
		.clk   (pclk),
		.rst_n (presetn),
		.q     (q.fifo)
	);

	assign loop = mc_ff[ump_pkg::MC_LOOP];
	assign ir   = mc_ff[ump_pkg::MC_IR];

	// pins cross into pclk through two flops before anything reads them
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_ff <= '1;
			sync2_ff <= '1;
		end else begin
			sync1_ff <= {infrared_strap_pin, rx_pin, cts_n_pin, dsr_n_pin, cd_n_pin, ri_n_pin};
			sync2_ff <= sync1_ff;
		end
	end

	// strap needs the synchroniser refilled after release before it is trusted
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			strap_cnt_ff <= '0;
		else if (!settled)
			strap_cnt_ff <= strap_cnt_ff + 2'h1;
	end
	assign settled = (strap_cnt_ff == ump_pkg::SETTLED);

	// apb: one wait state, answer registered
	assign done = psel & penable & pready_ff;
	assign wr   = done & pwrite;
	assign rd   = done & ~pwrite;

	always_comb begin
		nxt_prdata  = '0;
		nxt_pslverr = 1'b0;
		case (paddr)
			ump_pkg::OFF_HOLD: begin
				if (!q.empty)
					nxt_prdata[7:0] = q.top[ump_pkg::ENT_W-1:ump_pkg::ENT_DAT];
			end
			ump_pkg::OFF_IER: nxt_prdata[7:0] = ier_ff;
			ump_pkg::OFF_EFR: nxt_prdata[7:0] = efr_ff;
			ump_pkg::OFF_MC:  nxt_prdata[7:0] = mc_ff;
			ump_pkg::OFF_LS:  nxt_prdata[7:0] = line_status;
			ump_pkg::OFF_MS:  nxt_prdata[7:0] = {live, delta_ff};
			ump_pkg::OFF_FC:  nxt_prdata[7:0] = fc_ff;
			default:          nxt_pslverr     = 1'b1;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_ff  <= 1'b0;
			prdata_ff  <= '0;
			pslverr_ff <= 1'b0;
		end else begin
			pready_ff  <= psel & penable & ~pready_ff;
			prdata_ff  <= nxt_prdata;
			pslverr_ff <= nxt_pslverr & psel & penable & ~pready_ff;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ier_ff   <= '0;
			efr_ff   <= '0;
			fc_ff    <= '0;
			txdis_ff <= 1'b0;
		end else if (wr) begin
			if (paddr == ump_pkg::OFF_IER)
				ier_ff <= pwdata[7:0];
			if (paddr == ump_pkg::OFF_EFR)
				efr_ff <= pwdata[7:0];
			if (paddr == ump_pkg::OFF_FC)
				fc_ff <= pwdata[7:0];
			if (paddr == ump_pkg::OFF_MS)
				txdis_ff <= pwdata[ump_pkg::MS_TXDIS];
		end
	end

	// modem control; outside loopback, send-immediate arm is spent by whatever access comes next
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			mc_ff <= ump_pkg::MC_RST;
		else if (strap_cnt_ff == ump_pkg::STRAP_TAKE)
			mc_ff[ump_pkg::MC_IR] <= sync2_ff[ump_pkg::SY_STRAP];
		else if (wr && paddr == ump_pkg::OFF_MC)
			mc_ff <= pwdata[7:0];
		else if (done && !loop && mc_ff[ump_pkg::MC_IMM])
			mc_ff[ump_pkg::MC_IMM] <= 1'b0;
	end

	// holding writes: armed byte goes to the immediate slot outside loopback, others to the FIFO
	always_comb begin
		nxt_imm_pend = imm_pend_ff;
		if (imm_take)
			nxt_imm_pend = 1'b0;
		if (wr && paddr == ump_pkg::OFF_HOLD && mc_ff[ump_pkg::MC_IMM] && !loop && !txdis_ff)
			nxt_imm_pend = 1'b1;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			imm_pend_ff  <= 1'b0;
			imm_data_ff  <= '0;
			imm_valid_ff <= 1'b0;
			thr_push_ff  <= 1'b0;
			thr_data_ff  <= '0;
		end else begin
			imm_pend_ff  <= nxt_imm_pend;
			imm_valid_ff <= nxt_imm_pend & ~flow_char_pending & ~txdis_ff;
			thr_push_ff  <= 1'b0;
			if (wr && paddr == ump_pkg::OFF_HOLD) begin
				if (mc_ff[ump_pkg::MC_IMM] && !loop)
					imm_data_ff <= pwdata[7:0];
				else begin
					thr_push_ff <= 1'b1;
					thr_data_ff <= pwdata[7:0];
				end
			end
		end
	end

	// transmit status
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			thr_empty_ff <= 1'b1;
			tx_empty_ff  <= 1'b1;
		end else begin
			if (thr_push_ff)
				thr_empty_ff <= 1'b0;
			else if (tsr_load && tx_fifo_level == TXL_W'(1))
				thr_empty_ff <= 1'b1;
			tx_empty_ff <= thr_empty_ff & ~thr_push_ff & ~tsr_busy & ~tsr_load;
		end
	end

	// receive path; a break held low produces one entry only
	assign accept  = rx_char_done & ~(rx_break & brk_hold_ff);
	assign q.push  = accept & ~q.full;
	assign q.wdata = {rx_char, rx_break, rx_framing_err, rx_parity_err};
	assign q.pop   = rd & (paddr == ump_pkg::OFF_HOLD) & ~q.empty;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ovr_ff      <= 1'b0;
			brk_hold_ff <= 1'b0;
			xon_ff      <= 1'b0;
		end else begin
			if (accept && q.full)
				ovr_ff <= 1'b1;
			else if (rd && paddr == ump_pkg::OFF_LS)
				ovr_ff <= 1'b0;
			if (q.push && rx_break)
				brk_hold_ff <= 1'b1;
			else if (rx_serial_ff)
				brk_hold_ff <= 1'b0;
			xon_ff <= mc_ff[ump_pkg::MC_XANY] & sw_flow_halted & rx_char_done;
		end
	end

	// top-of-FIFO flags only mean something while a character is there
	assign line_status = {q.err_any,
		tx_empty_ff, thr_empty_ff,
		q.top[ump_pkg::ENT_BRK] & ~q.empty,
		q.top[ump_pkg::ENT_FE] & ~q.empty,
		q.top[ump_pkg::ENT_PE] & ~q.empty,
		ovr_ff, ~q.empty};

	// modem status: {cd, ri, dsr, cts} active high
	always_comb begin
		if (loop)
			live = {mc_ff[ump_pkg::MC_IMM], mc_ff[ump_pkg::MC_PAIR],
				mc_ff[ump_pkg::MC_DTR], mc_ff[ump_pkg::MC_RTS]};
		else
			live = ~{sync2_ff[ump_pkg::SY_CD], sync2_ff[ump_pkg::SY_RI],
				sync2_ff[ump_pkg::SY_DSR], sync2_ff[ump_pkg::SY_CTS]};
	end

	// a change landing on the read edge survives the clear
	always_comb begin
		nxt_delta = delta_ff;
		if (rd && paddr == ump_pkg::OFF_MS)
			nxt_delta = '0;
		if (settled) begin
			nxt_delta[3] = nxt_delta[3] | (live[3] ^ prev_ff[3]);
			nxt_delta[2] = nxt_delta[2] | (prev_ff[2] & ~live[2]);
			nxt_delta[1] = nxt_delta[1] | (live[1] ^ prev_ff[1]);
			nxt_delta[0] = nxt_delta[0] | (live[0] ^ prev_ff[0]);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev_ff   <= '0;
			delta_ff  <= '0;
			ms_int_ff <= 1'b0;
			ls_int_ff <= 1'b0;
		end else begin
			prev_ff   <= live;
			delta_ff  <= nxt_delta;
			ms_int_ff <= ier_ff[ump_pkg::IER_MS] & (|delta_ff);
			ls_int_ff <= ier_ff[ump_pkg::IER_LS] & (q.err_any | ovr_ff);
		end
	end

	// flow pins and auto flow halt; the transmitter stops at a char boundary
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			halt_ff  <= 1'b0;
			rts_n_ff <= 1'b1;
			dtr_n_ff <= 1'b1;
		end else begin
			halt_ff  <= efr_ff[ump_pkg::EFR_AUTO] &
				(mc_ff[ump_pkg::MC_PAIR] ? ~live[1] : ~live[0]);
			rts_n_ff <= ~mc_ff[ump_pkg::MC_RTS];
			dtr_n_ff <= ~mc_ff[ump_pkg::MC_DTR];
		end
	end

	// irda codec; bit phase realigns on every transmit edge
	assign rx_in = sync2_ff[ump_pkg::SY_RX] ^ fc_ff[ump_pkg::FC_IRINV];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase_ff     <= '0;
			tx_prev_ff   <= 1'b1;
			dec_cnt_ff   <= '0;
			tx_pin_ff    <= 1'b1;
			rx_serial_ff <= 1'b1;
		end else begin
			tx_prev_ff <= tx_serial;
			if (tx_serial != tx_prev_ff)
				phase_ff <= '0;
			else if (baud_tick16)
				phase_ff <= phase_ff + 4'h1;
			if (ir && rx_in)
				dec_cnt_ff <= ump_pkg::IR_HOLD_TICKS;
			else if (baud_tick16 && dec_cnt_ff != '0)
				dec_cnt_ff <= dec_cnt_ff - 5'h1;
			if (loop)
				tx_pin_ff <= ~ir;
			else if (ir)
				tx_pin_ff <= ~tx_serial & (phase_ff < ump_pkg::IR_PULSE_TICKS);
			else
				tx_pin_ff <= tx_serial;
			if (loop)
				rx_serial_ff <= tx_serial;
			else if (ir)
				rx_serial_ff <= (dec_cnt_ff == '0) & ~rx_in;
			else
				rx_serial_ff <= sync2_ff[ump_pkg::SY_RX];
		end
	end

	assign prdata           = prdata_ff;
	assign pready           = pready_ff;
	assign pslverr          = pslverr_ff;
	assign tx_pin           = tx_pin_ff;
	assign rts_n_pin        = rts_n_ff;
	assign dtr_n_pin        = dtr_n_ff;
	assign rx_serial        = rx_serial_ff;
	assign thr_push         = thr_push_ff;
	assign thr_data         = thr_data_ff;
	assign imm_valid        = imm_valid_ff;
	assign imm_data         = imm_data_ff;
	assign xon_any_resume   = xon_ff;
	assign tx_flow_halt     = halt_ff;
	assign tx_disable       = txdis_ff;
	assign line_status_int  = ls_int_ff;
	assign modem_status_int = ms_int_ff;
endmodule

// file: verification/uart_modem_line_status_ctrl_asserts.sv
// Purpose: port-level checks of the modem, line and modem-status block
// Assumes: single pclk domain, presetn asynchronous active low
// Notes:   pin checks allow two cycles of register delay after a write
`timescale 1ns/10ps
module uart_modem_line_status_ctrl_asserts (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        rts_n_pin,
	input wire logic        dtr_n_pin,
	input wire logic        sw_flow_halted,
	input wire logic        rx_char_done,
	input wire logic        xon_any_resume,
	input wire logic        thr_push,
	input wire logic        imm_valid,
	input wire logic        imm_take,
	input wire logic        flow_char_pending,
	input wire logic        tx_disable
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_answer;
		!pready ##1 pready;
	endsequence
	sequence s_mc_write;
		psel && penable && pready && pwrite && paddr == ump_pkg::OFF_MC && !pslverr;
	endsequence
	// three cycles so a registered gate has settled
	sequence s_disabled;
		tx_disable [*3];
	endsequence
	sequence s_flow_busy;
		flow_char_pending [*3];
	endsequence

	AST_APB_ANSWER: assert property (psel && !penable |=> s_answer)
		else $error("pready not in second access cycle");
	AST_SLVERR_DATA: assert property (pready && pslverr |-> prdata == 32'h0)
		else $error("refused transfer returned data");
	AST_RTS_PIN: assert property (s_mc_write |-> ##2 rts_n_pin == !$past(pwdata[1], 2))
		else $error("rts_n wrong");
	AST_DTR_PIN: assert property (s_mc_write |-> ##2 dtr_n_pin == !$past(pwdata[0], 2))
		else $error("dtr_n wrong");
	AST_XON_ANY: assert property (xon_any_resume |-> $past(sw_flow_halted && rx_char_done))
		else $error("resume without halted char");
	AST_THR_PUSH: assert property (thr_push |->
		$past(psel && penable && pready && pwrite && paddr == ump_pkg::OFF_HOLD))
		else $error("push without holding write");
	AST_IMM_TXDIS: assert property (s_disabled |-> !imm_valid)
		else $error("immediate byte while disabled");
	AST_IMM_FLOW: assert property (s_flow_busy |-> !imm_valid)
		else $error("immediate byte before flow chars");
	AST_IMM_TAKEN: assert property (imm_valid && imm_take |-> ##2 !imm_valid)
		else $error("immediate byte not retired");
	AST_TEMT: assert property (psel && penable && pready && !pwrite
		&& paddr == ump_pkg::OFF_LS |-> !(prdata[6] && !prdata[5]))
		else $error("tx empty while holding full");
endmodule

bind uart_modem_line_status_ctrl uart_modem_line_status_ctrl_asserts
	i_uart_modem_line_status_ctrl_asserts (.*);

// file: verification/modem_partner.sv
// Purpose: modem side: handshake inputs and receive line of the channel
// Assumes: lines change only just after a pclk edge
// Notes:   idle state is all handshakes inactive and line at mark
`timescale 1ns/10ps
module modem_partner (
	input  wire logic pclk,
	output logic      cts_n_pin,
	output logic      dsr_n_pin,
	output logic      cd_n_pin,
	output logic      ri_n_pin,
	output logic      rx_pin
);
	initial begin
		{cd_n_pin, ri_n_pin, dsr_n_pin, cts_n_pin, rx_pin} = 5'h1f;
	end
	// order {cd, ri, dsr, cts}, active low
	task automatic lines(input logic [3:0] v);
		@(posedge pclk);
		{cd_n_pin, ri_n_pin, dsr_n_pin, cts_n_pin} <= v;
		repeat (6) @(posedge pclk);
	endtask
	// returns once the change has crossed the synchroniser
	task automatic line_rx(input logic v);
		@(posedge pclk);
		rx_pin <= v;
		repeat (6) @(posedge pclk);
	endtask
endmodule

// file: verification/uart_modem_line_status_ctrl_tb.sv
// Purpose: self-checking bench of the modem, line and modem-status block
// Assumes: fifo depth cut to 8 so overrun is reached quickly
// Notes:   bench plays the transmit/receive core around the block
`timescale 1ns/10ps
module uart_modem_line_status_ctrl_tb;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rd_err;
	logic [7:0]  paddr, rx_char, thr_data, imm_data;
	logic [31:0] pwdata, prdata, rd_val;
	logic        infrared_strap_pin, rx_pin, cts_n_pin, dsr_n_pin, cd_n_pin, ri_n_pin;
	logic        tx_pin, rts_n_pin, dtr_n_pin, baud_tick16, tx_serial, tsr_load, tsr_busy;
	logic [6:0]  tx_fifo_level;
	logic        sw_flow_halted, flow_char_pending, imm_take, rx_char_done, rx_parity_err;
	logic        rx_framing_err, rx_break, rx_serial, thr_push, imm_valid, xon_any_resume;
	logic        tx_flow_halt, tx_disable, line_status_int, modem_status_int;
	int          error_cnt, tests_run;

	localparam logic [7:0] HO = ump_pkg::OFF_HOLD, IE = ump_pkg::OFF_IER, EF = ump_pkg::OFF_EFR;
	localparam logic [7:0] MC = ump_pkg::OFF_MC, LS = ump_pkg::OFF_LS, MS = ump_pkg::OFF_MS;

	uart_modem_line_status_ctrl #(.FIFO_DEPTH(8), .TXL_W(7)) i_uart_modem_line_status_ctrl (.*);
	modem_partner i_modem_partner (.*);

	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end
	always @(posedge pclk) baud_tick16 <= ~baud_tick16;

	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected %s: expected %h, seen %h", nm, exp, got);
		end
	endtask
	// request held until pready is seen high at an edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n = 0;
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd_val = prdata;
		rd_err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		if (n >= 20) error_cnt++;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a);
		apb(1'b0, a, 32'h0);
	endtask
	task automatic rxc(input logic [7:0] c, input logic [2:0] f);
		@(posedge pclk);
		rx_char_done <= 1'b1;
		rx_char      <= c;
		{rx_break, rx_framing_err, rx_parity_err} <= f;
		@(posedge pclk);
		rx_char_done <= 1'b0;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
		input string nm);
		rd(a);
		chk(nm, e, rd_val & m);
	endtask
	task automatic ls_chk(input logic [31:0] e, input string nm);
		rd_chk(LS, 32'h9f, e, nm);
	endtask
	task automatic ms_chk(input logic [31:0] e, input string nm);
		rd_chk(MS, 32'hff, e, nm);
	endtask

	task automatic t_reset();
		chk("infrared idle tx_pin", 0, tx_pin);
		chk("rts_n", 1, rts_n_pin);
		rd_chk(MC, 32'hffffffff, 32'h40, "modem_control");
		rd(8'h1c);
		chk("unmapped pslverr", 1, rd_err);
		chk("unmapped data", 0, rd_val);
		wr(MC, 32'h0);
		cyc(4);
		chk("plain idle tx_pin", 1, tx_pin);
		for (int v = 0; v < 4; v++) begin
			wr(MC, v);
			cyc(2);
			chk("rts_n", !v[1], rts_n_pin);
			chk("dtr_n", !v[0], dtr_n_pin);
		end
	endtask
	task automatic t_modem();
		wr(MC, 32'h0);
		wr(IE, 32'h08);
		rd(MS);
		i_modem_partner.lines(4'he);
		chk("modem int", 1, modem_status_int);
		ms_chk(32'h11, "modem_status cts");
		ms_chk(32'h10, "modem_status cleared");
		chk("modem int cleared", 0, modem_status_int);
		i_modem_partner.lines(4'ha);
		ms_chk(32'h50, "ring start");
		i_modem_partner.lines(4'he);
		ms_chk(32'h14, "ring end");
		i_modem_partner.lines(4'h4);
		ms_chk(32'hba, "cd dsr");
		i_modem_partner.lines(4'hf);
		ms_chk(32'h0b, "release");
		wr(IE, 32'h0);
	endtask
	task automatic t_loop();
		wr(MC, 32'h1f);
		tx_serial <= 1'b0;
		cyc(4);
		chk("loopback rx_serial", 0, rx_serial);
		chk("loopback tx_pin idle", 1, tx_pin);
		tx_serial <= 1'b1;
		rd_chk(MS, 32'hf0, 32'hf0, "loopback status");
		wr(MC, 32'h14);
		rd_chk(MS, 32'hf0, 32'h40, "loopback out one");
		wr(MC, 32'h0);
		cyc(6);
		rd(MS);
	endtask
	task automatic t_flow();
		wr(EF, 32'h40);
		cyc(4);
		chk("halt on cts high", 1, tx_flow_halt);
		i_modem_partner.lines(4'he);
		chk("resume on cts low", 0, tx_flow_halt);
		wr(MC, 32'h04);
		cyc(3);
		chk("halt on dsr high", 1, tx_flow_halt);
		wr(EF, 32'h0);
		cyc(3);
		chk("no halt without auto", 0, tx_flow_halt);
		wr(MC, 32'h0);
		i_modem_partner.lines(4'hf);
		rd(MS);
	endtask
	task automatic t_rx();
		wr(IE, 32'h04);
		rxc(8'h5a, 3'b001);
		cyc(3);
		chk("line int", 1, line_status_int);
		ls_chk(32'h85, "parity entry");
		rd_chk(HO, 32'hff, 32'h5a, "rx data");
		ls_chk(32'h0, "rx empty");
		chk("line int clear", 0, line_status_int);
		for (int i = 0; i < 9; i++) rxc(8'(i), 3'b000);
		ls_chk(32'h03, "overrun");
		for (int i = 0; i < 8; i++) rd_chk(HO, 32'hff, i, "fifo kept");
		rxc(8'h11, 3'b000);
		rxc(8'h22, 3'b010);
		ls_chk(32'h81, "error below top");
		rd(HO);
		ls_chk(32'h89, "framing at top");
		rd(HO);
		i_modem_partner.line_rx(1'b0);
		rxc(8'h0, 3'b100);
		rxc(8'h0, 3'b100);
		ls_chk(32'h91, "break");
		rd(HO);
		rd_chk(LS, 32'h81, 32'h0, "one break only");
		i_modem_partner.line_rx(1'b1);
		wr(IE, 32'h0);
	endtask
	task automatic t_tx();
		wr(HO, 32'h41);
		@(posedge pclk);
		chk("thr_push", 1, thr_push);
		chk("thr_data", 32'h41, thr_data);
		tx_fifo_level <= 7'h1;
		rd_chk(LS, 32'h60, 32'h0, "holding loaded");
		{tsr_load, tsr_busy} <= 2'b11;
		@(posedge pclk);
		{tsr_load, tx_fifo_level} <= {1'b0, 7'h0};
		rd_chk(LS, 32'h60, 32'h20, "shifting");
		tsr_busy <= 1'b0;
		cyc(2);
		rd_chk(LS, 32'h60, 32'h60, "all empty");
	endtask
	task automatic t_imm();
		wr(MC, 32'h08);
		wr(HO, 32'h55);
		@(posedge pclk);
		chk("no fifo push", 0, thr_push);
		cyc(2);
		chk("imm_valid", 1, imm_valid);
		chk("imm_data", 32'h55, imm_data);
		rd_chk(MC, 32'hff, 32'h0, "self clear");
		imm_take <= 1'b1;
		@(posedge pclk);
		imm_take <= 1'b0;
		cyc(2);
		chk("imm retired", 0, imm_valid);
		wr(MS, 32'h08);
		wr(MC, 32'h08);
		wr(HO, 32'h66);
		cyc(3);
		chk("refused while disabled", 0, imm_valid);
		chk("tx_disable", 1, tx_disable);
		wr(MS, 32'h0);
		flow_char_pending <= 1'b1;
		wr(MC, 32'h08);
		wr(HO, 32'h77);
		cyc(3);
		chk("after flow chars", 0, imm_valid);
		flow_char_pending <= 1'b0;
		cyc(3);
		chk("imm_data", 32'h77, imm_valid ? imm_data : 8'h0);
		imm_take <= 1'b1;
		@(posedge pclk);
		imm_take <= 1'b0;
	endtask
	task automatic t_xany();
		wr(MC, 32'h20);
		sw_flow_halted <= 1'b1;
		rxc(8'h13, 3'b000);
		@(posedge pclk);
		chk("xon any", 1, xon_any_resume);
		wr(MC, 32'h0);
		rxc(8'h13, 3'b000);
		@(posedge pclk);
		chk("xon any off", 0, xon_any_resume);
		sw_flow_halted <= 1'b0;
		rd(HO);
		rd(HO);
	endtask
	// second reset in mid-run with the strap low
	task automatic t_strap();
		infrared_strap_pin <= 1'b0;
		presetn <= 1'b0;
		cyc(2);
		presetn <= 1'b1;
		cyc(5);
		chk("plain tx_pin", 1, tx_pin);
		rd_chk(MC, 32'hff, 32'h0, "strap low");
	endtask

	task automatic results();
		$display("comparisons %0d, mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge pclk);
		error_cnt++;
		results();
	end
	initial begin
		{psel, penable, pwrite, paddr, pwdata, rx_char, tx_fifo_level} = '0;
		{baud_tick16, tsr_load, tsr_busy, sw_flow_halted, flow_char_pending, imm_take} = '0;
		{rx_char_done, rx_parity_err, rx_framing_err, rx_break} = '0;
		{infrared_strap_pin, tx_serial} = 2'b11;
		error_cnt = 0;
		tests_run = 0;
		presetn = 1'b0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		cyc(5);
		t_reset();
		t_modem();
		t_loop();
		t_flow();
		t_rx();
		t_tx();
		t_imm();
		t_xany();
		t_strap();
		results();
	end
endmodule
